// File: src/sat_supply_cfg.svh
// constants for the satellite supply control block
`ifndef SAT_SUPPLY_CFG_SVH
`define SAT_SUPPLY_CFG_SVH
`define REG_RESET 8'h00
`define BIT_OVERTEMP 1
`define BIT_OVERLOAD 0
`define CTRL_LSB 2
`define BYTE_BITS 4'h8
`define ADDR_GND 7'h08
`define ADDR_SEL1 7'h09
`define ADDR_SEL2 7'h0A
`define ADDR_SEL3 7'h0B
`define CLK_KHZ 100000
`define OFF_TIME_MS 900
`define ON_DIVIDER 10
`define SYNC_RESET 8'h03
`endif

// File: src/sat_supply_pkg.sv
// types shared by the satellite supply control block
package sat_supply_pkg;
    typedef struct packed {
        logic current_limit_mode;
        logic tx_output_enable;
        logic tone_force;
        logic line_comp;
        logic voltage_select;
        logic enable;
    } ctrl_t;
    typedef struct packed {
        logic tx_supply_output;
        logic rx_supply_output;
        logic tone_enable;
        logic voltage_select;
        logic line_comp;
        logic static_limit;
        logic regulator_on;
    } supply_t;
    typedef enum logic [2:0] {
        IDLE = 3'h0,
        ADDR = 3'h1,
        ADDR_ACK = 3'h3,
        WRITE = 3'h2,
        WRITE_ACK = 3'h6,
        READ = 3'h7,
        READ_ACK = 3'h5
    } i2c_state_t;
    typedef enum logic [1:0] {
        NORMAL = 2'h0,
        HOLD_OFF = 2'h1,
        RETRY_ON = 2'h3
    } ovl_state_t;
endpackage : sat_supply_pkg

// File: src/pin_sync.sv
// two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input logic clk,
    input logic rst,
    // pins in, synchronised levels out
    input logic [W-1:0] pins,
    output logic [W-1:0] levels
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] levels_d;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                meta_d[i] = pins[i];
                levels_d[i] = meta_q[i];
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_q[i] <= RST_VAL[i];
                    levels[i] <= RST_VAL[i];
                end else begin
                    meta_q[i] <= meta_d[i];
                    levels[i] <= levels_d[i];
                end
            end
        end
    endgenerate
endmodule : pin_sync

// File: src/overload_guard.sv
// overload flag and pulsed current-limit timer
`timescale 1ns/1ps
`include "sat_supply_cfg.svh"
module overload_guard #(
    parameter int OFF_CYCLES = `OFF_TIME_MS * `CLK_KHZ,
    parameter int ON_CYCLES = OFF_CYCLES / `ON_DIVIDER,
    parameter int CW = 27
) (
    // clock and reset
    input logic clk,
    input logic rst,
    // conditions
    input logic overcurrent,
    input logic armed,
    input logic pulsed,
    // results
    output logic flag,
    output logic shutoff
);
    sat_supply_pkg::ovl_state_t state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic flag_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        flag_d = flag;
        case (state_q)
            sat_supply_pkg::NORMAL: begin
                flag_d = overcurrent;
                if (pulsed && overcurrent) begin
                    state_d = sat_supply_pkg::HOLD_OFF;
                    cnt_d = CW'(OFF_CYCLES - 1);
                end
            end
            sat_supply_pkg::HOLD_OFF: begin
                if (cnt_q == '0) begin
                    state_d = sat_supply_pkg::RETRY_ON;
                    cnt_d = CW'(ON_CYCLES - 1);
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            sat_supply_pkg::RETRY_ON: begin
                if (overcurrent) begin
                    state_d = sat_supply_pkg::HOLD_OFF;
                    cnt_d = CW'(OFF_CYCLES - 1);
                end else if (cnt_q == '0) begin
                    state_d = sat_supply_pkg::NORMAL;
                    flag_d = 1'b0;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            default: state_d = sat_supply_pkg::NORMAL;
        endcase
        if (!pulsed) begin
            state_d = sat_supply_pkg::NORMAL;
            flag_d = overcurrent;
        end
        if (!armed) begin
            state_d = sat_supply_pkg::NORMAL;
            flag_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= sat_supply_pkg::NORMAL;
            cnt_q <= '0;
            flag <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            flag <= flag_d;
        end
    end

    assign shutoff = (state_q == sat_supply_pkg::HOLD_OFF);
endmodule : overload_guard

// File: src/satellite_supply_i2c_control.sv
// i2c slave, system register and supply control outputs
`timescale 1ns/1ps
`include "sat_supply_cfg.svh"
// Behaviour
// - address byte 0x10 write, 0x11 read
// - one data byte, acknowledge, then stop
// - register clears to zero at reset
// - writes update only six upper bits
// - bits 1,0 are read-only flags
// - voltage_select and line_comp drive level outputs
// - tone_force low: tone follows gate pin
// - tone_force high: tone on whenever power is on
// - tx disabled selects receive output
// - tx enabled switches transmit output on
// - current_limit_mode picks pulsed or static
// - read shifts register out MSB first
// - master ack sends another copy
// - master nack releases SDA, ends read
// - writable bits read back last write
// - over-temperature flag, power blocks off
// - overload flag while protection triggered
// - undervoltage: ignore bus, register zero
// - interface works once undervoltage clears
// - ground select answers address 0001000
// - enable low disables all power blocks
// - static mode flag follows clamp
// - pulsed mode off, retry, clear
module satellite_supply_i2c_control #(
    parameter int OFF_CYCLES = `OFF_TIME_MS * `CLK_KHZ,
    parameter logic [6:0] ADDR_SEL1 = `ADDR_SEL1,
    parameter logic [6:0] ADDR_SEL2 = `ADDR_SEL2,
    parameter logic [6:0] ADDR_SEL3 = `ADDR_SEL3
) (
    // clock and power-on reset
    input logic clk,
    input logic rst,
    // i2c pins
    input logic scl_in,
    input logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // status and select pins
    input logic undervoltage_lockout,
    input logic overtemp_in,
    input logic overcurrent_in,
    input logic tone_gate_in,
    input logic [1:0] addr_sel,
    // supply controls and register view
    output sat_supply_pkg::supply_t supply,
    output logic [7:0] system_register
);
    logic scl_s, sda_s, uvlo_s, overtemp_s, overcurrent_s, tone_gate_s;
    logic [1:0] addr_sel_s;
    logic scl_q, scl_d, sda_q, sda_d;
    logic scl_rise, scl_fall, start, stop;
    sat_supply_pkg::i2c_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic nack_q, nack_d;
    sat_supply_pkg::ctrl_t ctl_q, ctl_d;
    logic [6:0] own_addr;
    logic [7:0] rd_byte;
    logic ol_flag, ovl_shutoff, power_on;
    sat_supply_pkg::supply_t supply_d;
    logic [7:0] reg_d;

    pin_sync #(
        .W(8),
        .RST_VAL(`SYNC_RESET)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .pins({addr_sel, tone_gate_in, overcurrent_in, overtemp_in,
               undervoltage_lockout, sda_in, scl_in}),
        .levels({addr_sel_s, tone_gate_s, overcurrent_s, overtemp_s,
                 uvlo_s, sda_s, scl_s})
    );

    always_comb begin
        if (addr_sel_s == 2'h0) begin
            own_addr = `ADDR_GND;
        end else if (addr_sel_s == 2'h1) begin
            own_addr = ADDR_SEL1;
        end else if (addr_sel_s == 2'h2) begin
            own_addr = ADDR_SEL2;
        end else begin
            own_addr = ADDR_SEL3;
        end
    end

    assign rd_byte = {ctl_q, overtemp_s, ol_flag};
    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start = scl_s && scl_q && sda_q && !sda_s;
    assign stop = scl_s && scl_q && !sda_q && sda_s;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        nack_d = nack_q;
        ctl_d = ctl_q;
        scl_d = scl_s;
        sda_d = sda_s;
        case (state_q)
            sat_supply_pkg::ADDR, sat_supply_pkg::WRITE: begin
                if (scl_rise) begin
                    sh_d = {sh_q[6:0], sda_s};
                    cnt_d = cnt_q + 4'h1;
                end else if (scl_fall && cnt_q == `BYTE_BITS) begin
                    cnt_d = 4'h0;
                    if (state_q == sat_supply_pkg::WRITE) begin
                        state_d = sat_supply_pkg::WRITE_ACK;
                    end else if (sh_q[7:1] == own_addr) begin
                        state_d = sat_supply_pkg::ADDR_ACK;
                    end else begin
                        state_d = sat_supply_pkg::IDLE;
                    end
                end
            end
            sat_supply_pkg::ADDR_ACK: begin
                if (scl_fall) begin
                    if (sh_q[0]) begin
                        state_d = sat_supply_pkg::READ;
                        sh_d = rd_byte;
                    end else begin
                        state_d = sat_supply_pkg::WRITE;
                    end
                end
            end
            sat_supply_pkg::WRITE_ACK: begin
                if (scl_rise) begin
                    ctl_d = sat_supply_pkg::ctrl_t'(sh_q[7:`CTRL_LSB]);
                end
                if (scl_fall) begin
                    state_d = sat_supply_pkg::WRITE;
                end
            end
            sat_supply_pkg::READ: begin
                if (scl_fall) begin
                    sh_d = {sh_q[6:0], 1'b1};
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `BYTE_BITS - 4'h1) begin
                        state_d = sat_supply_pkg::READ_ACK;
                        cnt_d = 4'h0;
                    end
                end
            end
            sat_supply_pkg::READ_ACK: begin
                if (scl_rise) begin
                    nack_d = sda_s;
                end
                if (scl_fall) begin
                    if (nack_q) begin
                        state_d = sat_supply_pkg::IDLE;
                    end else begin
                        state_d = sat_supply_pkg::READ;
                        sh_d = rd_byte;
                    end
                end
            end
            default: state_d = sat_supply_pkg::IDLE;
        endcase
        if (start) begin
            state_d = sat_supply_pkg::ADDR;
            cnt_d = 4'h0;
        end
        if (stop) begin
            state_d = sat_supply_pkg::IDLE;
        end
        if (uvlo_s) begin
            state_d = sat_supply_pkg::IDLE;
            ctl_d = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= sat_supply_pkg::IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'hFF;
            nack_q <= 1'b1;
            ctl_q <= sat_supply_pkg::ctrl_t'(`REG_RESET >> `CTRL_LSB);
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            nack_q <= nack_d;
            ctl_q <= ctl_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_n = !((state_q == sat_supply_pkg::ADDR_ACK)
                        || (state_q == sat_supply_pkg::WRITE_ACK)
                        || (state_q == sat_supply_pkg::READ && !sh_q[7]));

    assign power_on = ctl_q.enable && !uvlo_s && !overtemp_s;

    overload_guard #(
        .OFF_CYCLES(OFF_CYCLES)
    ) u_overload (
        .clk(clk),
        .rst(rst),
        .overcurrent(overcurrent_s),
        .armed(power_on),
        .pulsed(!ctl_q.current_limit_mode),
        .flag(ol_flag),
        .shutoff(ovl_shutoff)
    );

    always_comb begin
        supply_d.regulator_on = power_on && !ovl_shutoff;
        supply_d.voltage_select = power_on && ctl_q.voltage_select;
        supply_d.line_comp = power_on && ctl_q.line_comp;
        supply_d.tone_enable = power_on && (ctl_q.tone_force || tone_gate_s);
        supply_d.tx_supply_output = supply_d.regulator_on && ctl_q.tx_output_enable;
        supply_d.rx_supply_output = supply_d.regulator_on && !ctl_q.tx_output_enable;
        supply_d.static_limit = ctl_q.current_limit_mode;
        reg_d = rd_byte;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supply <= '0;
            system_register <= `REG_RESET;
        end else begin
            supply <= supply_d;
            system_register <= reg_d;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_uvlo_clears;
        uvlo_s |=> (ctl_q == '0) && sda_oe_n;
    endproperty
    a_uvlo_clears: assert property (p_uvlo_clears)
        else $error("register not cleared under lockout");

    property p_commit;
        state_q == sat_supply_pkg::WRITE_ACK && scl_rise && !uvlo_s
            |=> ctl_q == $past(sh_q[7:2]);
    endproperty
    a_commit: assert property (p_commit)
        else $error("write byte not committed at ack");

    property p_hold;
        !(state_q == sat_supply_pkg::WRITE_ACK && scl_rise) && !uvlo_s |=> $stable(ctl_q);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed outside commit");

    property p_read_load;
        state_q == sat_supply_pkg::ADDR_ACK && scl_fall && sh_q[0] && !start && !stop
            && !uvlo_s |=> state_q == sat_supply_pkg::READ && sh_q == $past(rd_byte);
    endproperty
    a_read_load: assert property (p_read_load)
        else $error("read byte not loaded");

    property p_addr_miss;
        state_q == sat_supply_pkg::ADDR && scl_fall && cnt_q == `BYTE_BITS
            && sh_q[7:1] != own_addr && !uvlo_s |=> state_q == sat_supply_pkg::IDLE;
    endproperty
    a_addr_miss: assert property (p_addr_miss)
        else $error("foreign address acknowledged");

    property p_nack_end;
        state_q == sat_supply_pkg::READ_ACK && nack_q && scl_fall
            |=> state_q != sat_supply_pkg::READ ##1 sda_oe_n;
    endproperty
    a_nack_end: assert property (p_nack_end)
        else $error("read continued after nack");

    property p_tone_force;
        power_on && ctl_q.tone_force |=> supply.tone_enable;
    endproperty
    a_tone_force: assert property (p_tone_force)
        else $error("forced tone not on");

    property p_tone_gate;
        power_on && !ctl_q.tone_force |=> supply.tone_enable == $past(tone_gate_s);
    endproperty
    a_tone_gate: assert property (p_tone_gate)
        else $error("tone does not follow gate pin");

    property p_disabled;
        !ctl_q.enable |=> !supply.tx_supply_output && !supply.rx_supply_output
            && !supply.tone_enable && !supply.regulator_on;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("power block on while disabled");

    property p_rx_select;
        power_on && !ovl_shutoff && !ctl_q.tx_output_enable
            |=> supply.rx_supply_output && !supply.tx_supply_output;
    endproperty
    a_rx_select: assert property (p_rx_select)
        else $error("receive output not selected");

    property p_overtemp;
        overtemp_s |=> system_register[`BIT_OVERTEMP] && !supply.regulator_on;
    endproperty
    a_overtemp: assert property (p_overtemp)
        else $error("overtemp not reported");

    c_write: cover property (state_q == sat_supply_pkg::WRITE_ACK && scl_rise);
    c_read_ack: cover property (state_q == sat_supply_pkg::READ_ACK && scl_fall && !nack_q);
    c_read_nack: cover property (state_q == sat_supply_pkg::READ_ACK && scl_fall && nack_q);
    c_shutoff: cover property (ovl_shutoff);
endmodule : satellite_supply_i2c_control

// File: test/i2c_host_model.sv
// behavioural i2c master standing in for the host microcontroller
`timescale 1ns/1ps
module i2c_host_model (
    // bus lines, sda open drain
    output logic scl,
    output logic sda_oe_n,
    input wire logic sda
);
    localparam realtime Q = 31.25;
    // bus idles released, scl stands still high between frames
    initial begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
    end
    task automatic start_cond();
        // keep link edges off the sampling clock edge
        #1;
        sda_oe_n = 1'b1;
        scl = 1'b1;
        #Q sda_oe_n = 1'b0;
        #Q scl = 1'b0;
    endtask : start_cond
    // sda changes only while scl is low, sampled mid high phase
    task automatic bit_xfer(input logic b, output logic s);
        #Q sda_oe_n = b;
        #Q scl = 1'b1;
        #Q s = sda;
        #Q scl = 1'b0;
    endtask : bit_xfer
    task automatic stop_cond();
        #Q sda_oe_n = 1'b0;
        #Q scl = 1'b1;
        #Q sda_oe_n = 1'b1;
        #Q;
    endtask : stop_cond
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], s);
        end
        bit_xfer(1'b1, ack);
    endtask : write_byte
    // ack asks another copy, nack ends the read
    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(nack, s);
    endtask : read_byte
endmodule : i2c_host_model

// File: test/tb.sv
// self-checking bench for the satellite supply i2c control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
    localparam logic [6:0] SEL1 = 7'h19;
    localparam logic [6:0] SEL2 = 7'h2A;
    localparam logic [6:0] SEL3 = 7'h3C;
    logic clk, rst, scl, host_oe_n, sda_out, sda_oe_n, sda;
    logic uvlo, ot, oc, gate;
    logic [1:0] asel;
    sat_supply_pkg::supply_t supply;
    logic [7:0] sysreg, r1, r2;
    logic [4:0] kv;
    logic a, b;
    int checks = 0;
    int fails = 0;
    int n;
    assign sda = (sda_oe_n ? 1'b1 : sda_out) & host_oe_n;
    satellite_supply_i2c_control #(
        .OFF_CYCLES(200), .ADDR_SEL1(SEL1), .ADDR_SEL2(SEL2), .ADDR_SEL3(SEL3)
    ) i_satellite_supply_i2c_control (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .undervoltage_lockout(uvlo), .overtemp_in(ot),
        .overcurrent_in(oc), .tone_gate_in(gate), .addr_sel(asel),
        .supply(supply), .system_register(sysreg));
    i2c_host_model i_i2c_host_model (.scl(scl), .sda_oe_n(host_oe_n), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask : settle
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic reg_write(input logic [6:0] ad, input logic [7:0] d, output logic aa,
                             output logic ad_ack);
        i_i2c_host_model.start_cond();
        i_i2c_host_model.write_byte({ad, 1'b0}, aa);
        ad_ack = 1'b1;
        if (aa === 1'b0) begin
            i_i2c_host_model.write_byte(d, ad_ack);
        end
        i_i2c_host_model.stop_cond();
        settle();
    endtask : reg_write
    task automatic reg_read(output logic [7:0] d1, output logic [7:0] d2);
        logic aa;
        i_i2c_host_model.start_cond();
        i_i2c_host_model.write_byte({7'h08, 1'b1}, aa);
        `CHK("read addr ack", 1'b0, aa)
        i_i2c_host_model.read_byte(1'b0, d1);
        i_i2c_host_model.read_byte(1'b1, d2);
        repeat (4) @(posedge clk);
        `CHK("sda released", 1'b1, sda)
        i_i2c_host_model.stop_cond();
        settle();
    endtask : reg_read
    initial begin
        rst = 1'b1;
        uvlo = 1'b0;
        ot = 1'b0;
        oc = 1'b0;
        gate = 1'b0;
        asel = 2'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle();
        `CHK("reset reg", 8'h00, sysreg)
        `CHK("reset power", 1'b0, supply.regulator_on)
        reg_write(7'h08, 8'h7F, a, b);
        `CHK("addr ack", 1'b0, a)
        `CHK("data ack", 1'b0, b)
        `CHK("low bits kept", 8'h7C, sysreg)
        reg_read(r1, r2);
        `CHK("read byte", 8'h7C, r1)
        `CHK("read copy", 8'h7C, r2)
        for (int k = 0; k < 32; k++) begin
            kv = k[4:0];
            @(posedge clk);
            gate <= kv[1];
            reg_write(7'h08, {kv, 3'h7}, a, b);
            `CHK("ctrl reg", {kv, 3'h4}, sysreg)
            `CHK("level sel", kv[0], supply.voltage_select)
            `CHK("line comp", kv[1], supply.line_comp)
            `CHK("tone", kv[2] | kv[1], supply.tone_enable)
            `CHK("tx out", kv[3], supply.tx_supply_output)
            if (!kv[3]) `CHK("rx out", 1'b1, supply.rx_supply_output)
            `CHK("limit mode", kv[4], supply.static_limit)
            `CHK("power on", 1'b1, supply.regulator_on)
        end
        // host clears enable and tx, all power blocks off
        reg_write(7'h08, 8'h3B, a, b);
        `CHK("off power", 1'b0, supply.regulator_on)
        `CHK("off tx", 1'b0, supply.tx_supply_output)
        i_i2c_host_model.start_cond();
        i_i2c_host_model.write_byte(8'h10, a);
        repeat (4) i_i2c_host_model.bit_xfer(1'b0, b);
        i_i2c_host_model.stop_cond();
        settle();
        `CHK("abort keeps", 8'h38, sysreg)
        reg_write(7'h09, 8'h04, a, b);
        `CHK("other addr nack", 1'b1, a)
        `CHK("other addr reg", 8'h38, sysreg)
        asel <= 2'h1;
        settle();
        reg_write(SEL1, 8'h04, a, b);
        `CHK("sel1 ack", 1'b0, a)
        `CHK("sel1 reg", 8'h04, sysreg)
        reg_write(7'h08, 8'h00, a, b);
        `CHK("gnd addr nack", 1'b1, a)
        for (int s = 2; s < 4; s++) begin
            asel <= s[1:0];
            settle();
            reg_write(s == 2 ? SEL2 : SEL3, 8'h04, a, b);
            `CHK("sel ack", 1'b0, a)
            `CHK("sel reg", 8'h04, sysreg)
        end
        asel <= 2'h0;
        ot <= 1'b1;
        settle();
        `CHK("overtemp flag", 8'h06, sysreg)
        `CHK("overtemp power", 1'b0, supply.regulator_on)
        reg_read(r1, r2);
        `CHK("overtemp read", 8'h06, r1)
        ot <= 1'b0;
        reg_write(7'h08, 8'h84, a, b);
        oc <= 1'b1;
        settle();
        `CHK("static flag", 8'h85, sysreg)
        oc <= 1'b0;
        settle();
        `CHK("static clear", 8'h84, sysreg)
        reg_write(7'h08, 8'h04, a, b);
        oc <= 1'b1;
        repeat (5) @(posedge clk);
        oc <= 1'b0;
        repeat (100) @(posedge clk);
        `CHK("pulsed flag", 1'b1, sysreg[0])
        `CHK("pulsed off", 1'b0, supply.regulator_on)
        n = 0;
        while (sysreg[0] !== 1'b0 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 1000) begin
            fails++;
        end else begin
            `CHK("pulsed hold", 1'b1, n >= 115)
            uvlo <= 1'b1;
            settle();
            `CHK("lockout reg", 8'h00, sysreg)
            reg_write(7'h08, 8'h04, a, b);
            `CHK("lockout nack", 1'b1, a)
            uvlo <= 1'b0;
            settle();
            reg_write(7'h08, 8'h04, a, b);
            `CHK("after lockout", 8'h04, sysreg)
        end
        print_verdict();
    end
endmodule : tb
